//--- verilog/mctc_pkg.sv
// Package of constants for the multicast packet classifier
package mctc_pkg;

  // ==========================================================================
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] OFF_CAP       = 4'h0;
  localparam logic [3:0] OFF_CTRL      = 4'h1;
  localparam logic [3:0] OFF_BASE_LO   = 4'h2;
  localparam logic [3:0] OFF_BASE_HI   = 4'h3;
  localparam logic [3:0] OFF_BLKALL_LO = 4'h4;
  localparam logic [3:0] OFF_BLKALL_HI = 4'h5;
  localparam logic [3:0] OFF_BLKUT_LO  = 4'h6;
  localparam logic [3:0] OFF_BLKUT_HI  = 4'h7;
  localparam logic [3:0] OFF_PORTCFG   = 4'h8;
  localparam logic [3:0] OFF_STATUS    = 4'h9;
  localparam logic [3:0] OFF_LASTHDR0  = 4'ha;
  localparam logic [3:0] OFF_LASTHDR1  = 4'hb;
  localparam logic [3:0] OFF_COUNT     = 4'hc;

  // ==========================================================================
  // Field positions
  localparam int CTRL_ON_BIT      = 15;
  localparam int CTRL_NUM_LSB     = 0;
  localparam int BASE_EXP_LSB     = 0;
  localparam int BASE_ADDR_LSB    = 12;
  localparam int PORTCFG_UP_BIT   = 0;
  localparam int PORTCFG_LOAD_BIT = 1;
  localparam int ST_PRI_STA_BIT   = 0;
  localparam int ST_SEC_STA_BIT   = 1;
  localparam int ST_BLOCKED_BIT   = 2;

  // ==========================================================================
  // Reset values and limits
  localparam logic [5:0] MAXGRP_RESET  = 6'h1f;   // Means 32 groups
  localparam logic [5:0] MAXGRP_LIMIT  = 6'h3f;   // Means 64 groups
  localparam int         MAX_GROUPS    = 64;

  // ==========================================================================
  // Packet type codes as seen on the ingress header port
  localparam logic [1:0] PKT_OTHER     = 2'h0;
  localparam logic [1:0] PKT_MEM_WRITE = 2'h1;
  localparam logic [1:0] PKT_ADDR_MSG  = 2'h2;
  localparam logic [1:0] AT_UNTRANS    = 2'h0;

endpackage : mctc_pkg

//--- verilog/mctc_classifier.sv
// Multicast ingress classifier with per-group blocking checks
//
// Summary of operation
// - Up to 64 multicast groups per partition
// - Group capability resets to 32, loadable to 64
// - Multicast result stays in receiving partition
// - Only memory writes and address messages qualify
// - Multicast off means everything routes unicast
// - Multicast keeps posted ordering, no extra rules
// - Group regions contiguous, only enabled count decoded
// - Region size is two to the exponent
// - Base address is a full 64-bit value
// - Group n starts at base plus n regions
// - Zero low and group bits, compare base
// - Group ID taken starting at exponent bit
// - Group above enabled count means not multicast
// - Only source validation check applies to multicast
// - Block-all bit set blocks the packet
// - Block-untranslated bit plus untranslated AT blocks
// - Blocked packet dropped, credits returned
// - Blocked packet reported with header logged
// - Blocked sets signaled target abort flag
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module mctc_classifier #(
  parameter int GROUPS = 64
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESETN,
  // Register port
  input  wire logic [3:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  // Ingress packet header, one per cycle
  input  wire logic        I_PKT_VALID,
  input  wire logic [1:0]  I_PKT_TYPE,
  input  wire logic [63:0] I_PKT_ADDR,
  input  wire logic [1:0]  I_PKT_AT,
  input  wire logic [63:0] I_PKT_HDR,
  input  wire logic        I_PKT_SRC_OK,
  // Classification result, one cycle after the header
  output logic             O_RES_VALID,
  output logic             O_RES_MCAST,
  output logic [5:0]       O_RES_GROUP,
  output logic             O_RES_DROP,
  output logic             O_RES_ACS_FAIL,
  output logic             O_RES_CREDIT_RET,
  output logic             O_ERR_MC_BLOCKED,
  output logic [63:0]      O_ERR_HDR
);

  // ==========================================================================
  // Parameter check
  initial
  begin
    if (GROUPS < 1 || GROUPS > mctc_pkg::MAX_GROUPS)
      $error("GROUPS out of range");
  end

  // ==========================================================================
  // Design notes
  //
  // Register port
  //   Writes land on the edge that samples the write strobe.
  //   Reads are registered: data stand one cycle after the strobe.
  //   Outside that cycle the read data port shows zero.
  //   Unmapped indices read zero and ignore writes.
  //   Strobes may follow each other with no idle cycle.
  //
  // Capability field
  //   Resets to the 32-group code.
  //   Only a write with the init-load bit set changes it.
  //   Plain software writes leave the advertised count alone.
  //
  // Control register
  //   One enable bit and a six-bit enabled-count field.
  //   A count field of N enables N plus one groups.
  //   With enable clear no header is ever classified multicast.
  //
  // Base address
  //   Low word carries base bits 31:12 and the exponent.
  //   Base bits below 12 are forced to zero.
  //   High word carries base bits 63:32.
  //   Software must keep base bits under the group field zero.
  //   A nonzero bit there makes every compare miss.
  //
  // Classification
  //   Address bits below the exponent are masked off.
  //   Group-ID bits above the exponent are masked off too.
  //   The rest must equal the base for a hit.
  //   Group ID width grows with the enabled count.
  //   A group ID beyond the enabled count is not multicast.
  //   A group ID at or beyond GROUPS is not multicast either.
  //   Only memory writes and address messages are candidates.
  //   Every other type routes unicast, whatever its address.
  //
  // Blocking
  //   Block-all bit of the group blocks any multicast header that passes source validation.
  //   Block-untranslated bit blocks only untranslated headers.
  //   A header failing source validation is flagged, not blocked.
  //   Source validation itself is done outside this block.
  //
  // Blocked headers
  //   Dropped, with credits handed back in the same cycle.
  //   Reported as a blocked-multicast error pulse.
  //   Header copied to the error header output and the log.
  //   Upstream ports set the primary target-abort flag.
  //   Downstream ports set the secondary target-abort flag.
  //   A sticky blocked-seen flag and a counter record history.
  //
  // Status flags
  //   Cleared by writing ones.
  //   A block in the same cycle as the clear wins.
  //
  // Result stage
  //   One verdict per header, one cycle later, in arrival order.
  //   No buffering: a header per cycle is accepted and answered.
  //   The verdict never crosses to another partition's port.
  //
  // Hazards
  //   Routing fields must not change with traffic in flight.
  //   The datapath is one wide compare; timing may need care.
  //   The blocked counter wraps to zero on the 65536th event.
  //

  // ==========================================================================
  // Software state
  logic [5:0]  maxgrp_reg;
  logic        on_reg;
  logic [5:0]  num_reg;
  logic [5:0]  exp_reg;
  logic [63:0] base_reg;
  logic [63:0] blkall_reg;
  logic [63:0] blkut_reg;
  logic        upstream_reg;
  logic        pri_sta_reg;
  logic        sec_sta_reg;
  logic        blocked_reg;
  logic [63:0] lasthdr_reg;
  logic [15:0] count_reg;
  logic [31:0] rdata_reg;

  // Register write decode
  wire         wr_cap     = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_CAP);
  wire         wr_ctrl    = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_CTRL);
  wire         wr_base_lo = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BASE_LO);
  wire         wr_base_hi = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BASE_HI);
  wire         wr_ba_lo   = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BLKALL_LO);
  wire         wr_ba_hi   = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BLKALL_HI);
  wire         wr_bu_lo   = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BLKUT_LO);
  wire         wr_bu_hi   = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_BLKUT_HI);
  wire         wr_port    = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_PORTCFG);
  wire         wr_status  = I_REG_WR && (I_REG_ADDR == mctc_pkg::OFF_STATUS);
  // Capability rewrite allowed only with the init-load strobe bit
  wire         cap_load   = wr_cap && I_REG_WDATA[mctc_pkg::PORTCFG_LOAD_BIT + 15];
  wire [5:0]   cap_wval   = I_REG_WDATA[5:0];

  // ==========================================================================
  // Classification datapath
  wire [63:0]  low_mask   = (64'h1 << exp_reg) - 64'h1;
  wire [6:0]   grp_bits   = gid_width(num_reg);
  wire [63:0]  grp_field  = ((64'h1 << grp_bits) - 64'h1) << exp_reg;
  wire [63:0]  addr_mask  = ~(low_mask | grp_field);
  wire         base_hit   = ((I_PKT_ADDR & addr_mask) == base_reg);
  wire [63:0]  grp_shift  = (I_PKT_ADDR & grp_field) >> exp_reg;
  wire [5:0]   grp_id     = grp_shift[5:0];
  wire         grp_ok     = (grp_id <= num_reg) && (32'(grp_id) < GROUPS);
  wire         type_ok    = (I_PKT_TYPE == mctc_pkg::PKT_MEM_WRITE) ||
                            (I_PKT_TYPE == mctc_pkg::PKT_ADDR_MSG);
  wire         is_mcast   = on_reg && type_ok && base_hit && grp_ok;
  wire         acs_fail   = is_mcast && !I_PKT_SRC_OK;
  wire         blk_all    = blkall_reg[grp_id];
  wire         blk_ut     = blkut_reg[grp_id] &&
                            (I_PKT_AT == mctc_pkg::AT_UNTRANS);
  wire         blocked    = I_PKT_VALID && is_mcast && !acs_fail &&
                            (blk_all || blk_ut);

  // Number of group-ID bits: ceil(log2(count field + 1))
  function automatic logic [6:0] gid_width(input logic [5:0] n);
    logic [6:0] w;
    w = 7'h0;
    for (int i = 0; i < 7; i++)
    begin
      if ((7'(n) + 7'h1) > (7'h1 << i))
        w = 7'(i + 1);
    end
    return w;
  endfunction : gid_width

  // ==========================================================================
  // Capability and control registers
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      maxgrp_reg <= mctc_pkg::MAXGRP_RESET;
      on_reg     <= 1'b0;
      num_reg    <= 6'h00;
    end
    else
    begin
      if (cap_load)
        maxgrp_reg <= cap_wval;
      if (wr_ctrl)
      begin
        on_reg  <= I_REG_WDATA[mctc_pkg::CTRL_ON_BIT];
        num_reg <= I_REG_WDATA[mctc_pkg::CTRL_NUM_LSB +: 6];
      end
    end
  end

  // Base address, exponent and per-group block vectors
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      exp_reg    <= 6'h00;
      base_reg   <= 64'h0;
      blkall_reg <= 64'h0;
      blkut_reg  <= 64'h0;
    end
    else
    begin
      if (wr_base_lo)
      begin
        exp_reg        <= I_REG_WDATA[mctc_pkg::BASE_EXP_LSB +: 6];
        base_reg[31:0] <= {I_REG_WDATA[31:12], 12'h000};
      end
      if (wr_base_hi)
        base_reg[63:32] <= I_REG_WDATA;
      if (wr_ba_lo)
        blkall_reg[31:0] <= I_REG_WDATA;
      if (wr_ba_hi)
        blkall_reg[63:32] <= I_REG_WDATA;
      if (wr_bu_lo)
        blkut_reg[31:0] <= I_REG_WDATA;
      if (wr_bu_hi)
        blkut_reg[63:32] <= I_REG_WDATA;
    end
  end

  // Port role and sticky status; a new block wins over a write-one clear
  wire         clr_pri = wr_status && I_REG_WDATA[mctc_pkg::ST_PRI_STA_BIT];
  wire         clr_sec = wr_status && I_REG_WDATA[mctc_pkg::ST_SEC_STA_BIT];
  wire         clr_blk = wr_status && I_REG_WDATA[mctc_pkg::ST_BLOCKED_BIT];
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      upstream_reg <= 1'b0;
      pri_sta_reg  <= 1'b0;
      sec_sta_reg  <= 1'b0;
      blocked_reg  <= 1'b0;
    end
    else
    begin
      if (wr_port)
        upstream_reg <= I_REG_WDATA[mctc_pkg::PORTCFG_UP_BIT];
      pri_sta_reg <= (blocked && upstream_reg) || (pri_sta_reg && !clr_pri);
      sec_sta_reg <= (blocked && !upstream_reg) || (sec_sta_reg && !clr_sec);
      blocked_reg <= blocked || (blocked_reg && !clr_blk);
    end
  end

  // Header log of the last blocked packet and blocked packet count
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      lasthdr_reg <= 64'h0;
      count_reg   <= 16'h0000;
    end
    else if (blocked)
    begin
      lasthdr_reg <= I_PKT_HDR;
      count_reg   <= count_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Read data, valid only in the cycle after the read strobe
  wire [31:0] rd_mux =
    (I_REG_ADDR == mctc_pkg::OFF_CAP)       ? {26'h0, maxgrp_reg} :
    (I_REG_ADDR == mctc_pkg::OFF_CTRL)      ? {16'h0, on_reg, 9'h0, num_reg} :
    (I_REG_ADDR == mctc_pkg::OFF_BASE_LO)   ? {base_reg[31:12], 6'h0, exp_reg} :
    (I_REG_ADDR == mctc_pkg::OFF_BASE_HI)   ? base_reg[63:32] :
    (I_REG_ADDR == mctc_pkg::OFF_BLKALL_LO) ? blkall_reg[31:0] :
    (I_REG_ADDR == mctc_pkg::OFF_BLKALL_HI) ? blkall_reg[63:32] :
    (I_REG_ADDR == mctc_pkg::OFF_BLKUT_LO)  ? blkut_reg[31:0] :
    (I_REG_ADDR == mctc_pkg::OFF_BLKUT_HI)  ? blkut_reg[63:32] :
    (I_REG_ADDR == mctc_pkg::OFF_PORTCFG)   ? {31'h0, upstream_reg} :
    (I_REG_ADDR == mctc_pkg::OFF_STATUS)    ? {29'h0, blocked_reg, sec_sta_reg, pri_sta_reg} :
    (I_REG_ADDR == mctc_pkg::OFF_LASTHDR0)  ? lasthdr_reg[31:0] :
    (I_REG_ADDR == mctc_pkg::OFF_LASTHDR1)  ? lasthdr_reg[63:32] :
    (I_REG_ADDR == mctc_pkg::OFF_COUNT)     ? {16'h0, count_reg} : 32'h0;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
      rdata_reg <= 32'h0;
    else
      rdata_reg <= I_REG_RD ? rd_mux : 32'h0;
  end

  // ==========================================================================
  // Result stage: one registered verdict per header, in arrival order
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_RES_VALID      <= 1'b0;
      O_RES_MCAST      <= 1'b0;
      O_RES_GROUP      <= 6'h00;
      O_RES_DROP       <= 1'b0;
      O_RES_ACS_FAIL   <= 1'b0;
      O_RES_CREDIT_RET <= 1'b0;
      O_ERR_MC_BLOCKED <= 1'b0;
      O_ERR_HDR        <= 64'h0;
    end
    else
    begin
      O_RES_VALID      <= I_PKT_VALID;
      O_RES_MCAST      <= I_PKT_VALID && is_mcast;
      O_RES_GROUP      <= is_mcast ? grp_id : 6'h00;
      O_RES_DROP       <= blocked;
      O_RES_ACS_FAIL   <= I_PKT_VALID && acs_fail;
      O_RES_CREDIT_RET <= blocked;
      O_ERR_MC_BLOCKED <= blocked;
      O_ERR_HDR        <= blocked ? I_PKT_HDR : O_ERR_HDR;
    end
  end

  assign O_REG_RDATA = rdata_reg;

endmodule : mctc_classifier

`default_nettype wire

//--- tb/mctc_classifier_props.sv
// Port-level assertions for the multicast packet classifier
`timescale 1ns/1ns
`default_nettype none
module mctc_classifier_props #(
  parameter int GROUPS = 64
) (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESETN,
  input wire logic        I_PKT_VALID,
  input wire logic [1:0]  I_PKT_TYPE,
  input wire logic [63:0] I_PKT_HDR,
  input wire logic        I_PKT_SRC_OK,
  input wire logic        O_RES_VALID,
  input wire logic        O_RES_MCAST,
  input wire logic [5:0]  O_RES_GROUP,
  input wire logic        O_RES_DROP,
  input wire logic        O_RES_ACS_FAIL,
  input wire logic        O_RES_CREDIT_RET,
  input wire logic        O_ERR_MC_BLOCKED,
  input wire logic [63:0] O_ERR_HDR
);
  // ==========================================================================
  // Result timing, classification and blocking side effects
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_blocked;
    I_PKT_VALID ##1 O_RES_DROP;
  endsequence
  a_result_one_later: assert property (I_PKT_VALID |=> O_RES_VALID)
    else $error("no result one cycle after header");
  a_no_spurious_res: assert property (!I_PKT_VALID |=> !O_RES_VALID && !O_RES_DROP)
    else $error("result without header");
  a_type_gate: assert property (I_PKT_VALID && I_PKT_TYPE == mctc_pkg::PKT_OTHER |=> !O_RES_MCAST)
    else $error("other packet type marked multicast");
  a_drop_is_mcast: assert property (O_RES_DROP |-> O_RES_VALID && O_RES_MCAST)
    else $error("drop on a non-multicast result");
  a_credit_with_drop: assert property (O_RES_CREDIT_RET == O_RES_DROP)
    else $error("credit return differs from drop");
  a_report_with_drop: assert property (O_ERR_MC_BLOCKED == O_RES_DROP)
    else $error("blocked report differs from drop");
  a_header_logged: assert property (s_blocked |-> O_ERR_HDR == $past(I_PKT_HDR))
    else $error("logged header wrong");
  a_acs_not_block: assert property (O_RES_ACS_FAIL |-> O_RES_MCAST && !O_RES_DROP)
    else $error("source check flag on wrong packet");
  a_acs_cause: assert property (I_PKT_VALID && I_PKT_SRC_OK |=> !O_RES_ACS_FAIL)
    else $error("source check failed on good packet");
  a_group_range: assert property (O_RES_MCAST |-> O_RES_GROUP < GROUPS)
    else $error("group id out of range");
endmodule : mctc_classifier_props
bind mctc_classifier mctc_classifier_props #(.GROUPS(GROUPS)) u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_PKT_VALID(I_PKT_VALID),
  .I_PKT_TYPE(I_PKT_TYPE), .I_PKT_HDR(I_PKT_HDR), .I_PKT_SRC_OK(I_PKT_SRC_OK),
  .O_RES_VALID(O_RES_VALID), .O_RES_MCAST(O_RES_MCAST), .O_RES_GROUP(O_RES_GROUP),
  .O_RES_DROP(O_RES_DROP), .O_RES_ACS_FAIL(O_RES_ACS_FAIL),
  .O_RES_CREDIT_RET(O_RES_CREDIT_RET), .O_ERR_MC_BLOCKED(O_ERR_MC_BLOCKED),
  .O_ERR_HDR(O_ERR_HDR));
`default_nettype wire

//--- tb/mctc_link_model.sv
// Link partner model that sends ingress packet headers
`timescale 1ns/1ns
`default_nettype none
module mctc_link_model (
  input  wire logic        i_clk,
  output logic             o_valid,
  output logic [1:0]       o_type,
  output logic [63:0]      o_addr,
  output logic [1:0]       o_at,
  output logic [63:0]      o_hdr,
  output logic             o_src_ok
);
  // ==========================================================================
  // Idle lines, then one header per call; released address and header lines carry inverted data
  initial
  begin
    o_valid = 1'b0;
    o_type = 2'h0;
    o_addr = 64'h0;
    o_at = 2'h0;
    o_hdr = 64'h0;
    o_src_ok = 1'b1;
  end
  task automatic send(input logic [1:0] t, input logic [63:0] a, input logic [1:0] at,
                      input logic ok);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_type <= t;
    o_addr <= a;
    o_at <= at;
    o_hdr <= {a[31:0], a[63:32]};
    o_src_ok <= ok;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_hdr <= ~{a[31:0], a[63:32]};
  endtask : send
endmodule : mctc_link_model
`default_nettype wire

//--- tb/multicast_tlp_classifier_tb_top.sv
// Self-checking testbench for the multicast packet classifier
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module multicast_tlp_classifier_tb_top;
  // ==========================================================================
  // Clock, reset, register port and result wires
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  r_addr = 4'h0;
  logic [31:0] r_wdata = 32'h0;
  logic        r_wr = 1'b0;
  logic        r_rd = 1'b0;
  logic [31:0] rdata;
  logic        p_valid, p_ok, res_valid, mc, drop, acs, cred, err;
  logic [1:0]  p_type, p_at;
  logic [5:0]  grp;
  logic [63:0] p_addr, p_hdr, ehdr;
  int          num_errors = 0;
  int          checked = 0;
  always #50 clk = ~clk;
  mctc_link_model mdl (.i_clk(clk), .o_valid(p_valid), .o_type(p_type), .o_addr(p_addr),
    .o_at(p_at), .o_hdr(p_hdr), .o_src_ok(p_ok));
  mctc_classifier #(.GROUPS(64)) uut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_REG_ADDR(r_addr),
    .I_REG_WDATA(r_wdata), .I_REG_WR(r_wr), .I_REG_RD(r_rd), .O_REG_RDATA(rdata),
    .I_PKT_VALID(p_valid), .I_PKT_TYPE(p_type), .I_PKT_ADDR(p_addr), .I_PKT_AT(p_at),
    .I_PKT_HDR(p_hdr), .I_PKT_SRC_OK(p_ok), .O_RES_VALID(res_valid), .O_RES_MCAST(mc),
    .O_RES_GROUP(grp), .O_RES_DROP(drop), .O_RES_ACS_FAIL(acs), .O_RES_CREDIT_RET(cred),
    .O_ERR_MC_BLOCKED(err), .O_ERR_HDR(ehdr));
  // ==========================================================================
  // Bus, packet and closing tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    r_addr <= a;
    r_wdata <= d;
    r_wr <= 1'b1;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    r_addr <= a;
    r_rd <= 1'b1;
    @(posedge clk);
    r_rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rdc
  task automatic pkt(input logic [1:0] t, input logic [63:0] a, input logic [1:0] at,
    input logic ok, input logic m, input logic [5:0] g, input logic dr, input logic af);
    logic [63:0] h;
    h = {a[31:0], a[63:32]};
    mdl.send(t, a, at, ok);
    #1;
    `CHK("res_valid", 1'b1, res_valid)
    `CHK("mcast", m, mc)
    `CHK("group", g, grp)
    `CHK("drop", dr, drop)
    `CHK("credit", dr, cred)
    `CHK("aer", dr, err)
    `CHK("acs", af, acs)
    if (dr)
      `CHK("hdr", h, ehdr)
  endtask : pkt
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Scenarios; configuration changes happen only with the link quiet
  task automatic t_reset;
    rdc(mctc_pkg::OFF_CAP, 32'h1f);
    wr(mctc_pkg::OFF_CAP, 32'h3f);
    rdc(mctc_pkg::OFF_CAP, 32'h1f);
    wr(mctc_pkg::OFF_CAP, 32'h1003f);
    rdc(mctc_pkg::OFF_CAP, 32'h3f);
    rdc(4'hd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_classify;
    wr(mctc_pkg::OFF_CTRL, 32'h8003);
    wr(mctc_pkg::OFF_BASE_LO, 32'hc);
    wr(mctc_pkg::OFF_BASE_HI, 32'h1);
    for (int t = 0; t < 3; t++)
      pkt(t[1:0], 64'h1_0000_2000, 2'h1, 1'b1, t != 0, t != 0 ? 6'h2 : 6'h0, 1'b0, 1'b0);
    pkt(2'h1, 64'h1_0000_3010, 2'h1, 1'b1, 1'b1, 6'h3, 1'b0, 1'b0);
    pkt(2'h1, 64'h2_0000_2000, 2'h1, 1'b1, 1'b0, 6'h0, 1'b0, 1'b0);
    pkt(2'h1, 64'h1_0000_4000, 2'h1, 1'b1, 1'b0, 6'h0, 1'b0, 1'b0);
    wr(mctc_pkg::OFF_BASE_LO, 32'h10);
    pkt(2'h2, 64'h1_0001_0000, 2'h1, 1'b1, 1'b1, 6'h1, 1'b0, 1'b0);
    wr(mctc_pkg::OFF_BASE_LO, 32'hc);
    wr(mctc_pkg::OFF_CTRL, 32'h8002);
    pkt(2'h1, 64'h1_0000_3000, 2'h1, 1'b1, 1'b0, 6'h0, 1'b0, 1'b0);
    pkt(2'h1, 64'h1_0000_2000, 2'h1, 1'b1, 1'b1, 6'h2, 1'b0, 1'b0);
    wr(mctc_pkg::OFF_CTRL, 32'h0003);
    pkt(2'h1, 64'h1_0000_2000, 2'h1, 1'b1, 1'b0, 6'h0, 1'b0, 1'b0);
    $display("test classify done");
  endtask : t_classify
  task automatic t_block;
    wr(mctc_pkg::OFF_CTRL, 32'h8003);
    wr(mctc_pkg::OFF_BLKALL_LO, 32'h2);
    wr(mctc_pkg::OFF_PORTCFG, 32'h1);
    pkt(2'h1, 64'h1_0000_1000, 2'h1, 1'b1, 1'b1, 6'h1, 1'b1, 1'b0);
    rdc(mctc_pkg::OFF_STATUS, 32'h5);
    wr(mctc_pkg::OFF_STATUS, 32'h7);
    rdc(mctc_pkg::OFF_STATUS, 32'h0);
    wr(mctc_pkg::OFF_PORTCFG, 32'h0);
    pkt(2'h2, 64'h1_0000_1000, 2'h1, 1'b1, 1'b1, 6'h1, 1'b1, 1'b0);
    rdc(mctc_pkg::OFF_STATUS, 32'h6);
    wr(mctc_pkg::OFF_BLKALL_LO, 32'h0);
    wr(mctc_pkg::OFF_BLKUT_LO, 32'h4);
    pkt(2'h1, 64'h1_0000_2000, 2'h0, 1'b1, 1'b1, 6'h2, 1'b1, 1'b0);
    pkt(2'h1, 64'h1_0000_2000, 2'h1, 1'b1, 1'b1, 6'h2, 1'b0, 1'b0);
    pkt(2'h1, 64'h1_0000_0000, 2'h1, 1'b0, 1'b1, 6'h0, 1'b0, 1'b1);
    wr(mctc_pkg::OFF_CTRL, 32'h803f);
    wr(mctc_pkg::OFF_BLKALL_HI, 32'h1);
    pkt(2'h1, 64'h1_0002_0000, 2'h1, 1'b1, 1'b1, 6'h20, 1'b1, 1'b0);
    rdc(mctc_pkg::OFF_COUNT, 32'h4);
    rdc(mctc_pkg::OFF_LASTHDR0, 32'h1);
    rdc(mctc_pkg::OFF_LASTHDR1, 32'h20000);
    $display("test block done");
  endtask : t_block
  // Main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_classify();
    t_block();
    stop_test();
  end
  initial
  begin
    #1000000;
    num_errors++;
    stop_test();
  end
endmodule : multicast_tlp_classifier_tb_top
`default_nettype wire
